// *** hw/lpi_pkg.sv ***
// Constants and carrier types of the low-power DDR pin interface.
// Assumes a single system clock that oversamples the link clock and strobes.
package lpi_pkg;
    localparam int LPI_DQ_W = 32;             // Wide configuration data width
    localparam int LPI_DQ_W_NARROW = 16;      // Narrow configuration data width
    localparam int LPI_LANES = LPI_DQ_W / 8;  // One strobe and one mask per byte lane
    localparam int LPI_CA_W = 10;             // Command/address pins
    localparam int LPI_BEATS = 4;             // Beats per prefetch
    localparam int LPI_PF_W = LPI_DQ_W * LPI_BEATS; // Prefetch word width
    localparam int LPI_MEM_AW = 4;            // Prefetch slot address bits of the little store
    localparam int LPI_CMD_W = 2 * LPI_CA_W + 2;
    localparam logic [1:0] LPI_OP_NOP = 2'h0; // Decoded operation codes
    localparam logic [1:0] LPI_OP_WR = 2'h1;
    localparam logic [1:0] LPI_OP_RD = 2'h2;
    localparam logic [1:0] LPI_OP_OTHER = 2'h3;

    // Captured command: rising and falling halves plus single-rate bits
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic [LPI_CA_W-1:0] ca_r;
        logic [LPI_CA_W-1:0] ca_f;
    } lpi_cmd_t;

    // One byte-lane strobe and output enable bundle going out
    typedef struct packed {
        logic [LPI_LANES-1:0] t;
        logic [LPI_LANES-1:0] c;
        logic [LPI_LANES-1:0] oe;
    } lpi_dqs_t;
endpackage

// *** hw/lpi_pf_mem.sv ***
// Prefetch store: holds four-beat words written and read by the pin logic.
// Assumes one clock; read data comes out of a register one cycle after the request.
`timescale 1ns/1ns
module lpi_pf_mem
    import lpi_pkg::*;
(
    input wire logic clk_sys_i,                    // System clock
    input wire logic we_i,                         // Write strobe
    input wire logic [LPI_MEM_AW-1:0] waddr_i,     // Write slot
    input wire logic [LPI_PF_W-1:0] wdata_i,       // Write word
    input wire logic [LPI_PF_W/8-1:0] wbe_i,       // Byte enables, low mask bits
    input wire logic [LPI_MEM_AW-1:0] raddr_i,     // Read slot
    output logic [LPI_PF_W-1:0] rdata_o            // Registered read word
);
    logic [LPI_PF_W-1:0] mem_q [2**LPI_MEM_AW]; // Storage array

    // Byte-masked write; masked bytes keep old content
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < LPI_PF_W / 8; i++) begin
            if (we_i && wbe_i[i]) begin
                mem_q[waddr_i][i*8 +: 8] <= wdata_i[i*8 +: 8];
            end
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule

// *** hw/lpi_pin_if.sv ***
// Device side pin logic of a low-power DDR memory: command capture, clock
// enable gating, and the byte-laned data path with strobes and masks.
// Assumes clk_sys_i runs much faster than the link clock and strobes, which
// are sampled as ordinary asynchronous inputs through two flip-flops.
`timescale 1ns/1ns
module lpi_pin_if
    import lpi_pkg::*;
#(
    parameter bit WIDE = 1'b1                         // Wide or narrow configuration
)
(
    input wire logic clk_sys_i,                       // System clock, 10 MHz
    input wire logic rst_n_i,                         // Asynchronous reset, active low
    input wire logic ck_t_i,                          // Link clock, true phase
    input wire logic ck_c_i,                          // Link clock, complement phase
    input wire logic cke_i,                           // Clock enable
    input wire logic cs_n_i,                          // Chip select, active low
    input wire logic [LPI_CA_W-1:0] ca_i,             // Command/address bus
    input wire logic [LPI_DQ_W-1:0] dq_i,             // Data bus, pin level
    output logic [LPI_DQ_W-1:0] dq_o,                 // Data bus, driven value
    output logic [LPI_DQ_W-1:0] dq_oe_o,              // Data bus output enable
    input wire logic [LPI_LANES-1:0] dqs_t_i,         // Strobe true, pin level
    input wire logic [LPI_LANES-1:0] dqs_c_i,         // Strobe complement, pin level
    output logic [LPI_LANES-1:0] dqs_t_o,             // Strobe true, driven
    output logic [LPI_LANES-1:0] dqs_c_o,             // Strobe complement, driven
    output logic [LPI_LANES-1:0] dqs_oe_o,            // Strobe output enable
    input wire logic [LPI_LANES-1:0] dm_i,            // Write data masks
    output logic power_down_o,                        // Device in power saving
    output logic [1:0] last_op_o,                     // Last decoded operation
    output logic [LPI_CA_W-1:0] col_addr_o            // Last column, bit 0 zero
);
    localparam int NL = WIDE ? LPI_LANES : LPI_DQ_W_NARROW / 8; // Live lanes

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,   // Waiting for a command
        ST_WR = 4'b0010,     // Collecting write beats
        ST_RD = 4'b0100,     // Driving read beats
        ST_PD = 4'b1000      // Power saving, clocks gated
    } lpi_state_t;

    typedef struct packed {
        logic [1:0] ck_t_s1, ck_t_s2;         // Link clock synchronisers
        logic [1:0] ck_c_s1, ck_c_s2;
        logic ck_prev;                        // Last settled differential level
        logic cke_s1, cke_s2, cs_s1, cs_s2;   // Single-rate synchronisers
        logic [LPI_CA_W-1:0] ca_s1, ca_s2;
        logic [LPI_LANES-1:0] dqs_s1, dqs_s2, dqs_prev;
        logic [LPI_LANES-1:0] dqsc_s1, dqsc_s2;   // Complement strobe synchronisers
        logic [LPI_LANES-1:0] dm_s1, dm_s2;
        logic [LPI_DQ_W-1:0] dq_s1, dq_s2;
        lpi_cmd_t cmd;                        // Command being assembled
        lpi_state_t st;
        logic [1:0] beat;                     // Beat index within prefetch
        logic [LPI_PF_W-1:0] pf;              // Write prefetch gathered
        logic [LPI_PF_W/8-1:0] be;            // Byte enables gathered
        logic mem_we;
        logic [LPI_DQ_W-1:0] dq;
        logic dq_oe;
        logic [LPI_LANES-1:0] dqs_lvl;
        logic [1:0] op;
        logic [LPI_CA_W-1:0] col;
        logic [LPI_MEM_AW-1:0] slot;
    } lpi_reg_t;

    lpi_reg_t r_q, r_d;                       // All state of the module
    logic [LPI_PF_W-1:0] rd_word;             // Word from prefetch store
    logic ck_now, ck_pos, ck_neg;             // Differential edge events
    logic [LPI_LANES-1:0] dqs_edge;           // Any strobe edge per lane
    logic [LPI_LANES-1:0] dqs_now;            // Settled differential strobe level

    // Decode the operation from all three command inputs together
    function automatic logic [1:0] decode_op(input lpi_cmd_t c);
        if (!c.cke || c.cs_n) begin
            decode_op = LPI_OP_NOP;
        end else if (c.ca_r[2:0] == 3'h1) begin
            decode_op = LPI_OP_RD;
        end else if (c.ca_r[2:0] == 3'h0) begin
            decode_op = LPI_OP_WR;
        end else begin
            decode_op = LPI_OP_OTHER;
        end
    endfunction

    // Differential level: only a clean pair counts, otherwise hold
    assign ck_now = (r_q.ck_t_s2[0] != r_q.ck_c_s2[0]) ? r_q.ck_t_s2[0] : r_q.ck_prev;
    assign ck_pos = ck_now && !r_q.ck_prev;
    assign ck_neg = !ck_now && r_q.ck_prev;
    // Strobe level resolved only after both phases are synchronised;
    // an unclean pair holds the last level so no false beat is taken
    assign dqs_now = ((r_q.dqs_s2 ^ r_q.dqsc_s2) & r_q.dqs_s2)
        | (~(r_q.dqs_s2 ^ r_q.dqsc_s2) & r_q.dqs_prev);
    assign dqs_edge = dqs_now ^ r_q.dqs_prev;

    lpi_pf_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .we_i(r_q.mem_we),
        .waddr_i(r_q.slot),
        .wdata_i(r_q.pf),
        .wbe_i(r_q.be),
        .raddr_i(r_q.slot),
        .rdata_o(rd_word)
    );

    // Next state of everything
    always_comb begin
        r_d = r_q;
        r_d.ck_t_s1 = {1'b0, ck_t_i};
        r_d.ck_t_s2 = r_q.ck_t_s1;
        r_d.ck_c_s1 = {1'b0, ck_c_i};
        r_d.ck_c_s2 = r_q.ck_c_s1;
        r_d.ck_prev = ck_now;
        r_d.cke_s1 = cke_i;
        r_d.cke_s2 = r_q.cke_s1;
        r_d.cs_s1 = cs_n_i;
        r_d.cs_s2 = r_q.cs_s1;
        r_d.ca_s1 = ca_i;
        r_d.ca_s2 = r_q.ca_s1;
        r_d.dqs_s1 = dqs_t_i;
        r_d.dqs_s2 = r_q.dqs_s1;
        r_d.dqsc_s1 = dqs_c_i;
        r_d.dqsc_s2 = r_q.dqsc_s1;
        r_d.dqs_prev = dqs_now;
        r_d.dm_s1 = dm_i;
        r_d.dm_s2 = r_q.dm_s1;
        r_d.dq_s1 = dq_i;
        r_d.dq_s2 = r_q.dq_s1;
        r_d.mem_we = 1'b0;
        // Rising edge: single-rate and first half of the address
        if (ck_pos) begin
            r_d.cmd.cke = r_q.cke_s2;
            r_d.cmd.cs_n = r_q.cs_s2;
            r_d.cmd.ca_r = r_q.ca_s2;
        end
        case (r_q.st)
            ST_IDLE: begin
                if (ck_pos && !r_q.cke_s2) begin
                    r_d.st = ST_PD;
                end else if (ck_neg) begin
                    // Enable low at the rising half decodes as NOP, never a stale op
                    r_d.cmd.ca_f = r_q.ca_s2;
                    r_d.op = decode_op(r_q.cmd);
                    // Column bit 0 never travels; force it low
                    r_d.col = {r_q.ca_s2[LPI_CA_W-1:1], 1'b0};
                    r_d.slot = r_q.ca_s2[LPI_MEM_AW:1];
                    r_d.beat = 2'h0;
                    r_d.be = '0;
                    if (decode_op(r_q.cmd) == LPI_OP_WR) begin
                        r_d.st = ST_WR;
                    end else if (decode_op(r_q.cmd) == LPI_OP_RD) begin
                        r_d.st = ST_RD;
                        r_d.dq_oe = 1'b0;
                    end else begin
                        r_d.st = ST_IDLE;
                    end
                end
            end
            ST_WR: begin
                // One beat per strobe edge on lane 0; masks sampled alongside
                if (dqs_edge[0]) begin
                    for (int l = 0; l < LPI_LANES; l++) begin
                        r_d.pf[r_q.beat*LPI_DQ_W + l*8 +: 8] = r_q.dq_s2[l*8 +: 8];
                        r_d.be[r_q.beat*LPI_LANES + l] = !r_q.dm_s2[l] && (l < NL);
                    end
                    r_d.beat = r_q.beat + 2'h1;
                    if (r_q.beat == 2'(LPI_BEATS - 1)) begin
                        r_d.mem_we = 1'b1;
                        r_d.st = ST_IDLE;
                    end
                end
                if (ck_pos && !r_q.cke_s2) begin
                    r_d.st = ST_IDLE;
                end
            end
            ST_RD: begin
                // Data and strobe change together on every link clock edge
                if (ck_pos || ck_neg) begin
                    r_d.dq_oe = 1'b1;
                    r_d.dq = rd_word[r_q.beat*LPI_DQ_W +: LPI_DQ_W];
                    r_d.dqs_lvl = {LPI_LANES{~r_q.beat[0]}};
                    r_d.beat = r_q.beat + 2'h1;
                    if (r_q.dq_oe && r_q.beat == 2'h0) begin
                        r_d.dq_oe = 1'b0;
                        r_d.st = ST_IDLE;
                    end
                end
                if (ck_pos && !r_q.cke_s2) begin
                    r_d.dq_oe = 1'b0;
                    r_d.st = ST_PD;
                end
            end
            ST_PD: begin
                // Only a clock enable rise wakes the device
                r_d.dq_oe = 1'b0;
                if (ck_pos && r_q.cke_s2) begin
                    r_d.st = ST_IDLE;
                    r_d.cmd.cke = 1'b0; // Wake edge itself carries no command
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
    end

    // Register all state; reset values are constants only
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.cmd.cs_n <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs; narrow configuration keeps upper lanes released
    generate
        for (genvar l = 0; l < LPI_LANES; l++) begin : g_lane
            assign dq_o[l*8 +: 8] = r_q.dq[l*8 +: 8];
            assign dq_oe_o[l*8 +: 8] = {8{r_q.dq_oe && (l < NL)}};
            assign dqs_t_o[l] = r_q.dqs_lvl[l];
            assign dqs_c_o[l] = ~r_q.dqs_lvl[l];
            assign dqs_oe_o[l] = r_q.dq_oe && (l < NL);
        end
    endgenerate
    assign power_down_o = (r_q.st == ST_PD);
    assign last_op_o = r_q.op;
    assign col_addr_o = r_q.col;

    // Assertions
    property p_col_zero;
        @(posedge clk_sys_i) disable iff (!rst_n_i) col_addr_o[0] == 1'b0;
    endproperty
    a_col_zero: assert property (p_col_zero) else $error("column bit 0 set");

    property p_pd_quiet;
        @(posedge clk_sys_i) disable iff (!rst_n_i) power_down_o |=> dq_oe_o == '0;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("driving in power down");

    property p_pd_entry;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            (r_q.st == ST_IDLE && ck_pos && !r_q.cke_s2) |=> power_down_o;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("no power down entry");

    property p_pd_stay;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            (power_down_o && !(ck_pos && r_q.cke_s2)) |=> power_down_o;
    endproperty
    a_pd_stay: assert property (p_pd_stay) else $error("left power down without enable");

    property p_strobe_with_data;
        @(posedge clk_sys_i) disable iff (!rst_n_i) dqs_oe_o[0] == dq_oe_o[0];
    endproperty
    a_strobe_with_data: assert property (p_strobe_with_data) else $error("strobe split");

    property p_idle_release;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            (r_q.st != ST_RD) |=> (r_q.st != ST_RD) |-> (dq_oe_o == '0);
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("bus not released");

    property p_nop_on_deselect;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            (r_q.st == ST_IDLE && ck_neg && r_q.cmd.cs_n) |=> last_op_o == LPI_OP_NOP;
    endproperty
    a_nop_on_deselect: assert property (p_nop_on_deselect) else $error("deselect decoded");

    property p_cs_rising_only;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            !ck_pos |=> r_q.cmd.cs_n == $past(r_q.cmd.cs_n);
    endproperty
    a_cs_rising_only: assert property (p_cs_rising_only) else $error("select off edge");

    property p_dqs_toggle;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            (r_q.st == ST_RD && (ck_pos || ck_neg) && r_q.beat == 2'h1) |=> dqs_t_o[0] == 1'b0;
    endproperty
    a_dqs_toggle: assert property (p_dqs_toggle) else $error("strobe not aligned");

    property p_write_commit;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
            (r_q.st == ST_WR && dqs_edge[0] && r_q.beat == 2'h3) |=> r_q.mem_we;
    endproperty
    a_write_commit: assert property (p_write_commit) else $error("prefetch not stored");

    // Read launch in two steps: first link edge in read, then beat 0 on the pins
    sequence s_rd_first_edge;
        r_q.st == ST_RD && (ck_pos || ck_neg) && r_q.beat == 2'h0 && !r_q.dq_oe
            && !(ck_pos && !r_q.cke_s2);
    endsequence
    sequence s_rd_beat0_out;
        dq_oe_o[0] && dqs_oe_o[0] && dqs_t_o[0] && !dqs_c_o[0];
    endsequence
    property p_rd_launch;
        @(posedge clk_sys_i) disable iff (!rst_n_i) s_rd_first_edge |=> s_rd_beat0_out;
    endproperty
    a_rd_launch: assert property (p_rd_launch) else $error("read beat 0 not launched");
endmodule

// *** verif/lpi_host_model.sv ***
// Host controller model: makes the link clock, commands and write bursts.
// Assumes the bench resolves shared data and strobe pins from both enables.
`timescale 1ns/1ns
module lpi_host_model
    import lpi_pkg::*;
(
    input wire logic clk_sys_i,                  // System clock
    input wire logic [LPI_DQ_W-1:0] dq_i,        // Data pin level
    input wire logic [LPI_LANES-1:0] dqs_t_i,    // Strobe true pin level
    output logic ck_t_o,                         // Link clock, true
    output logic ck_c_o,                         // Link clock, complement
    output logic cke_o,                          // Clock enable
    output logic cs_n_o,                         // Chip select, active low
    output logic [LPI_CA_W-1:0] ca_o,            // Command/address
    output logic [LPI_DQ_W-1:0] dq_o,            // Write data, inverted once released
    output logic [LPI_LANES-1:0] dqs_t_o,        // Strobe true
    output logic [LPI_LANES-1:0] dqs_c_o,        // Strobe complement
    output logic [LPI_LANES-1:0] dm_o            // Write masks
);
    // Complement strobe always mirrors the true phase
    assign dqs_c_o = ~dqs_t_o;
    // Idle link: clock parked low, device deselected
    initial begin
        ck_t_o = 1'b0;
        ck_c_o = 1'b1;
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        ca_o = '0;
        dq_o = '0;
        dqs_t_o = '0;
        dm_o = '0;
    end
    // One link half of four system clocks; called at a falling system edge
    task automatic half(input logic t);
        ck_t_o = t;
        ck_c_o = ~t;
        repeat (4) @(negedge clk_sys_i);
    endtask
    // Command: select and enable only matter at the rising crossing
    task automatic cmd(input logic ke, input logic sr, input logic sf,
                       input logic [LPI_CA_W-1:0] car, input logic [LPI_CA_W-1:0] caf);
        cke_o = ke;
        cs_n_o = sr;
        ca_o = car;
        half(1'b1);
        cs_n_o = sf;
        ca_o = caf;
        half(1'b0);
        cs_n_o = 1'b1;
    endtask
    // Write burst: strobe toggles two clocks into each six-clock beat on every lane, mask rides with data
    task automatic wr_burst(input logic [LPI_PF_W-1:0] d,
                            input logic [LPI_BEATS*LPI_LANES-1:0] m);
        for (int k = 0; k < LPI_BEATS; k++) begin
            dq_o = d[k*LPI_DQ_W +: LPI_DQ_W];
            dm_o = m[k*LPI_LANES +: LPI_LANES];
            repeat (2) @(negedge clk_sys_i);
            dqs_t_o = ~dqs_t_o;
            repeat (4) @(negedge clk_sys_i);
        end
        // Released lines must not keep showing the last beat
        dq_o = ~dq_o;
        dqs_t_o = ~dqs_t_o;
        dm_o = '0;
    endtask
    // Read burst: one beat per link edge, then one extra clock pair
    task automatic rd_burst(output logic [LPI_PF_W-1:0] d,
                            output logic [LPI_BEATS*LPI_LANES-1:0] s);
        for (int k = 0; k < LPI_BEATS; k++) begin
            half(~k[0]);
            d[k*LPI_DQ_W +: LPI_DQ_W] = dq_i;
            s[k*LPI_LANES +: LPI_LANES] = dqs_t_i;
        end
        half(1'b1);
        half(1'b0);
    endtask
endmodule

// *** verif/testbench.sv ***
// Bench for the device pin logic: host model on the link, one task per case.
// Assumes the wide configuration and a 10 MHz system clock.
`timescale 1ns/1ns
module testbench
    import lpi_pkg::*;
;
    localparam logic [LPI_PF_W-1:0] WORD_A = 128'hD0D1_D2D3_C0C1_C2C3_B0B1_B2B3_A0A1_A2A3;
    localparam logic [LPI_PF_W-1:0] WORD_B = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
    logic clk_sys, rst_n, ck_t, ck_c, cke, cs_n, pdn;
    logic [LPI_CA_W-1:0] ca, col;
    logic [LPI_DQ_W-1:0] dq_h, dq_d, dq_oe, dq_p;
    logic [LPI_LANES-1:0] qs_h, qsc_h, qs_d, qsc_d, qs_oe, qs_p, qsc_p, dm;
    logic [1:0] last_op;
    int n_fail = 0;
    int n_compared = 0;
    // Pin level: whoever enables wins, else the host's released value
    assign dq_p = (dq_oe & dq_d) | (~dq_oe & dq_h);
    assign qs_p = (qs_oe & qs_d) | (~qs_oe & qs_h);
    assign qsc_p = (qs_oe & qsc_d) | (~qs_oe & qsc_h);
    always #50 clk_sys = ~clk_sys;
    lpi_host_model lpi_host_model_i (.clk_sys_i(clk_sys), .dq_i(dq_p), .dqs_t_i(qs_p),
        .ck_t_o(ck_t), .ck_c_o(ck_c), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca), .dq_o(dq_h),
        .dqs_t_o(qs_h), .dqs_c_o(qsc_h), .dm_o(dm));
    lpi_pin_if lpi_pin_if_i (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .ck_t_i(ck_t),
        .ck_c_i(ck_c), .cke_i(cke), .cs_n_i(cs_n), .ca_i(ca), .dq_i(dq_p), .dq_o(dq_d),
        .dq_oe_o(dq_oe), .dqs_t_i(qs_p), .dqs_c_i(qsc_p), .dqs_t_o(qs_d), .dqs_c_o(qsc_d),
        .dqs_oe_o(qs_oe), .dm_i(dm), .power_down_o(pdn), .last_op_o(last_op),
        .col_addr_o(col));
    // Single comparison point; case inequality so unknowns never match
    task automatic chk(input string nm, input logic [LPI_PF_W-1:0] seen,
                       input logic [LPI_PF_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and end of run, shared with the watchdog
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Quiet outputs straight after reset
    task automatic t_reset();
        chk("oe", {dq_oe, qs_oe}, '0);
        chk("power_down", pdn, 1'b0);
        chk("strobe_c", qsc_d, 4'hF);
        chk("last_op", last_op, LPI_OP_NOP);
        $display("reset test done");
    endtask
    // Write a full word, read it back; select high on the falling half
    task automatic t_write_read();
        logic [LPI_PF_W-1:0] d;
        logic [LPI_BEATS*LPI_LANES-1:0] s;
        lpi_host_model_i.cmd(1'b1, 1'b0, 1'b1, 10'h000, 10'h00B);
        chk("last_op", last_op, LPI_OP_WR);
        chk("col", col, 10'h00A);
        lpi_host_model_i.wr_burst(WORD_A, 16'h0000);
        lpi_host_model_i.cmd(1'b1, 1'b0, 1'b1, 10'h001, 10'h00B);
        chk("last_op", last_op, LPI_OP_RD);
        lpi_host_model_i.rd_burst(d, s);
        chk("read", d, WORD_A);
        chk("strobe", s, 16'h0F0F);
        chk("oe", {dq_oe, qs_oe}, '0);
        $display("write read test done");
    endtask
    // Beat k masks lane k: those bytes must keep the old word
    task automatic t_mask();
        logic [LPI_PF_W-1:0] d, e;
        logic [LPI_BEATS*LPI_LANES-1:0] s;
        e = WORD_B;
        for (int k = 0; k < LPI_BEATS; k++) begin
            e[k*LPI_DQ_W+8*k +: 8] = WORD_A[k*LPI_DQ_W+8*k +: 8];
        end
        lpi_host_model_i.cmd(1'b1, 1'b0, 1'b0, 10'h000, 10'h00A);
        lpi_host_model_i.wr_burst(WORD_B, 16'h8421);
        lpi_host_model_i.cmd(1'b1, 1'b0, 1'b0, 10'h001, 10'h00A);
        lpi_host_model_i.rd_burst(d, s);
        chk("masked read", d, e);
        $display("mask test done");
    endtask
    // Other opcode, then select low only on the falling half
    task automatic t_decode();
        lpi_host_model_i.cmd(1'b1, 1'b0, 1'b1, 10'h003, 10'h002);
        chk("last_op", last_op, LPI_OP_OTHER);
        lpi_host_model_i.cmd(1'b1, 1'b1, 1'b0, 10'h001, 10'h00B);
        chk("last_op", last_op, LPI_OP_NOP);
        lpi_host_model_i.cmd(1'b1, 1'b1, 1'b1, 10'h000, 10'h000);
        chk("oe", {dq_oe, qs_oe}, '0);
        $display("decode test done");
    endtask
    // Enable low enters power saving, a read is refused, enable high leaves
    task automatic t_power();
        lpi_host_model_i.cmd(1'b0, 1'b1, 1'b1, 10'h000, 10'h000);
        chk("power_down", pdn, 1'b1);
        lpi_host_model_i.cmd(1'b0, 1'b0, 1'b0, 10'h001, 10'h00B);
        chk("power_down", pdn, 1'b1);
        chk("last_op", last_op, LPI_OP_NOP);
        lpi_host_model_i.cmd(1'b1, 1'b1, 1'b1, 10'h000, 10'h000);
        chk("power_down", pdn, 1'b0);
        $display("power test done");
    endtask
    // Watchdog: the whole run needs well under a thousand clocks
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        $display("watchdog expired");
        end_of_test();
    end
    // Main sequence: reset for 16 clocks, then the cases in order
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_reset();
        t_write_read();
        t_mask();
        t_decode();
        t_power();
        end_of_test();
    end
endmodule
